/* File: rtl/srxp_pkg.sv */
/*
 Package for the serial-link receiver PLL and test register bank.
 Holds register offsets, reset values, field layouts and decode tables.
 Assumes an 8-bit register port with 16-bit byte offsets.
*/
package srxp_pkg;

  localparam logic [15:0] OFS_STATUS = 16'h0107;
  localparam logic [15:0] OFS_PHY_PLL_REF_DIVIDER = 16'h0108;
  localparam logic [15:0] OFS_MULT = 16'h0109;
  localparam logic [15:0] OFS_RATE = 16'h010a;
  localparam logic [15:0] OFS_VCO = 16'h010b;
  localparam logic [15:0] OFS_SYNC = 16'h0120;
  localparam logic [15:0] OFS_PRBS = 16'h0121;
  localparam logic [15:0] OFS_WDOG = 16'h0124;

  localparam logic [7:0] RST_PHY_PLL_REF_DIVIDER = 8'h30;
  localparam logic [7:0] RST_MULT = 8'h14;
  localparam logic [7:0] RST_RATE = 8'h00;
  localparam logic [7:0] RST_VCO = 8'h00;
  localparam logic [7:0] RST_SYNC = 8'h01;
  localparam logic [7:0] RST_PRBS = 8'h00;
  localparam logic [7:0] RST_WDOG = 8'h00;

  localparam int STATUS_SYNC_BIT = 5;
  localparam int WDOG_PLL_BIT = 7;

  localparam logic [7:0] MULT_X4 = 8'h10;
  localparam logic [7:0] MULT_X5 = 8'h14;
  localparam logic [7:0] MULT_X8Q = 8'h21;
  localparam logic [7:0] MULT_X10 = 8'h28;

  // Watchdog thresholds as powers of two
  localparam int WDOG_EXP1 = 17;
  localparam int WDOG_EXP2 = 19;
  localparam int WDOG_EXP3 = 21;
  localparam int WDOG_EXP4 = 23;
  localparam int WDOG_W = 24;

  typedef enum logic [2:0] {
    SRXP_PRBS_OFF = 3'b000,
    SRXP_PRBS7 = 3'b001,
    SRXP_PRBS9 = 3'b010,
    SRXP_PRBS15 = 3'b011,
    SRXP_PRBS31 = 3'b100
  } srxp_prbs_t;

  // Decoded settings handed to the PHY
  typedef struct packed {
    logic [5:0] ref_divisor;
    logic [5:0] mult_quarters;
    logic mult_valid;
    logic [3:0] rate_halves;
    logic vco_low_range_flag;
    srxp_prbs_t prbs_mode;
    logic prbs_check_en;
  } srxp_cfg_t;

  // Line rate = f_clk * num / (den * 8)
  typedef struct packed {
    logic [9:0] num;
    logic [5:0] den;
  } srxp_ratio_t;

endpackage

/* File: rtl/srxp_wdog.sv */
/*
 Link watchdog counter for the receiver PHY.
 Assumes link_up and enable come from logic on sys_clk.
*/
`timescale 1ns/1ps
module srxp_wdog
  import srxp_pkg::*;
#(
  parameter int unsigned TH1 = 1 << WDOG_EXP1,
  parameter int unsigned TH2 = 1 << WDOG_EXP2,
  parameter int unsigned TH3 = 1 << WDOG_EXP3,
  parameter int unsigned TH4 = 1 << WDOG_EXP4
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic enable,
  input wire logic link_up,
  input wire logic [2:0] threshold_code,
  output logic expired
);

  logic [WDOG_W-1:0] cnt_q, cnt_d, limit;
  logic expired_d;

  always_comb begin
    case (threshold_code)
      3'd1: limit = WDOG_W'(TH1);
      3'd2: limit = WDOG_W'(TH2);
      3'd3: limit = WDOG_W'(TH3);
      3'd4: limit = WDOG_W'(TH4);
      default: limit = '0;
    endcase
  end

  always_comb begin
    cnt_d = cnt_q;
    expired_d = 1'b0;
    // Code zero or reserved codes leave the watchdog idle
    if (!enable || limit == '0) begin
      cnt_d = '0;
    end else if (cnt_q + 1'b1 >= limit && !link_up) begin
      cnt_d = '0;
      expired_d = 1'b1;
    end else if (!link_up) begin
      cnt_d = cnt_q + 1'b1;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      cnt_q <= '0;
      expired <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      expired <= expired_d;
    end
  end

endmodule

/* File: rtl/srxp_regs.sv */
/*
 Receiver PLL, line-rate, sync and test configuration register bank.
 Assumes a byte-wide register port on sys_clk and PHY logic on sys_clk.
*/
// Notes on behaviour
// - Six-bit reference divisor, resets to 48
// - Multiplier codes 0x10,0x14,0x21,0x28 decode
// - Rate field picks 4, 2, 1, 0.5
// - Writing zero forces the sync request
// - Pattern code 0 normal, 1-4 PRBS
// - Status bit reads sync state, low asserted
// - Watchdog codes 0 and 5-7 disable, 1-4 reset
`timescale 1ns/1ps
module srxp_regs
  import srxp_pkg::*;
#(
  parameter int unsigned WDOG_TH1 = 1 << WDOG_EXP1,
  parameter int unsigned WDOG_TH2 = 1 << WDOG_EXP2,
  parameter int unsigned WDOG_TH3 = 1 << WDOG_EXP3,
  parameter int unsigned WDOG_TH4 = 1 << WDOG_EXP4
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic link_enable,
  input wire logic link_up,
  input wire logic link_sync_req_low,
  output logic sync_req_low,
  output srxp_cfg_t cfg,
  output srxp_ratio_t line_ratio,
  output logic phy_reset,
  output logic phy_pll_reset
);

  logic [7:0] phy_pll_ref_divider_q, phy_pll_ref_divider_d, mult_q, mult_d, rate_q, rate_d;
  logic [7:0] vco_q, vco_d, sync_q, sync_d, prbs_q, prbs_d;
  logic [7:0] wdog_q, wdog_d, rdata_d;
  logic sync_req_low_d, wdog_expired;
  srxp_cfg_t cfg_d;
  srxp_ratio_t ratio_d;

  function automatic logic [5:0] mult_to_quarters(input logic [7:0] code);
    case (code)
      MULT_X4, MULT_X5, MULT_X8Q, MULT_X10: mult_to_quarters = code[5:0];
      default: mult_to_quarters = 6'h00;
    endcase
  endfunction

  function automatic logic [3:0] rate_to_halves(input logic [1:0] code);
    case (code)
      2'b00: rate_to_halves = 4'h8;
      2'b01: rate_to_halves = 4'h4;
      2'b10: rate_to_halves = 4'h2;
      default: rate_to_halves = 4'h1;
    endcase
  endfunction

  // Register writes; full bytes kept so reserved bits read back
  always_comb begin
    phy_pll_ref_divider_d = phy_pll_ref_divider_q;
    mult_d = mult_q;
    rate_d = rate_q;
    vco_d = vco_q;
    sync_d = sync_q;
    prbs_d = prbs_q;
    wdog_d = wdog_q;
    if (reg_wr) begin
      case (reg_addr)
        OFS_PHY_PLL_REF_DIVIDER: phy_pll_ref_divider_d = reg_wdata;
        OFS_MULT: mult_d = reg_wdata;
        OFS_RATE: rate_d = reg_wdata;
        OFS_VCO: vco_d = reg_wdata;
        OFS_SYNC: sync_d = reg_wdata;
        OFS_PRBS: prbs_d = reg_wdata;
        OFS_WDOG: wdog_d = reg_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      phy_pll_ref_divider_q <= RST_PHY_PLL_REF_DIVIDER;
      mult_q <= RST_MULT;
      rate_q <= RST_RATE;
      vco_q <= RST_VCO;
      sync_q <= RST_SYNC;
      prbs_q <= RST_PRBS;
      wdog_q <= RST_WDOG;
    end else begin
      phy_pll_ref_divider_q <= phy_pll_ref_divider_d;
      mult_q <= mult_d;
      rate_q <= rate_d;
      vco_q <= vco_d;
      sync_q <= sync_d;
      prbs_q <= prbs_d;
      wdog_q <= wdog_d;
    end
  end

  // Decoded settings; values are not held off while the link runs,
  // software is trusted to change them only with the link disabled
  always_comb begin
    cfg_d.ref_divisor = phy_pll_ref_divider_q[5:0];
    cfg_d.mult_quarters = mult_to_quarters(mult_q);
    cfg_d.mult_valid = (cfg_d.mult_quarters != 6'h00);
    cfg_d.rate_halves = rate_to_halves(rate_q[1:0]);
    cfg_d.vco_low_range_flag = vco_q[0];
    case (prbs_q[4:0])
      5'd1: cfg_d.prbs_mode = SRXP_PRBS7;
      5'd2: cfg_d.prbs_mode = SRXP_PRBS9;
      5'd3: cfg_d.prbs_mode = SRXP_PRBS15;
      5'd4: cfg_d.prbs_mode = SRXP_PRBS31;
      default: cfg_d.prbs_mode = SRXP_PRBS_OFF;
    endcase
    cfg_d.prbs_check_en = (cfg_d.prbs_mode != SRXP_PRBS_OFF);
    // Ratio in eighths: quarters of multiplier times halves of rate
    // Widen before the product, 40 quarters times 8 halves needs 9 bits
    ratio_d.num = 10'(cfg_d.mult_quarters) * 10'(cfg_d.rate_halves);
    ratio_d.den = phy_pll_ref_divider_q[5:0];
    // Manual request joins the link layer's own request
    sync_req_low_d = sync_q[0] & link_sync_req_low;
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      cfg <= '0;
      line_ratio <= '0;
      sync_req_low <= 1'b1;
    end else begin
      cfg <= cfg_d;
      line_ratio <= ratio_d;
      sync_req_low <= sync_req_low_d;
    end
  end

  srxp_wdog #(
    .TH1(WDOG_TH1),
    .TH2(WDOG_TH2),
    .TH3(WDOG_TH3),
    .TH4(WDOG_TH4)
  ) u_wdog (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .enable(link_enable),
    .link_up(link_up),
    .threshold_code(wdog_q[2:0]),
    .expired(wdog_expired)
  );

  assign phy_reset = wdog_expired;
  assign phy_pll_reset = wdog_expired & wdog_q[WDOG_PLL_BIT];

  // Read path; unmapped offsets read zero
  always_comb begin
    rdata_d = 8'h00;
    case (reg_addr)
      OFS_STATUS: rdata_d[STATUS_SYNC_BIT] = sync_req_low;
      OFS_PHY_PLL_REF_DIVIDER: rdata_d = phy_pll_ref_divider_q;
      OFS_MULT: rdata_d = mult_q;
      OFS_RATE: rdata_d = rate_q;
      OFS_VCO: rdata_d = vco_q;
      OFS_SYNC: rdata_d = sync_q;
      OFS_PRBS: rdata_d = prbs_q;
      OFS_WDOG: rdata_d = wdog_q;
      default: rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rdata <= reg_rd ? rdata_d : reg_rdata;
      reg_rvalid <= reg_rd;
    end
  end

endmodule

/* File: bench/srxp_chk.sv */
/* Checker for the srxp_regs ports.
 Assumes one clock and resetn active low. */
`timescale 1ns/1ps
module srxp_chk
  import srxp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic link_enable,
  input wire logic link_up,
  input wire logic link_sync_req_low,
  input wire logic sync_req_low,
  input wire srxp_cfg_t cfg,
  input wire srxp_ratio_t line_ratio,
  input wire logic phy_reset,
  input wire logic phy_pll_reset
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  rd_answer_a: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered");
  div_update_a: assert property (reg_wr && reg_addr == OFS_PHY_PLL_REF_DIVIDER |=> ##1
    cfg.ref_divisor == $past(reg_wdata[5:0], 2)) else $error("divisor");
  mult_decode_a: assert property (reg_wr && reg_addr == OFS_MULT &&
    reg_wdata == MULT_X8Q |=> ##1 cfg.mult_quarters == 6'h21)
    else $error("multiplier");
  rate_decode_a: assert property (reg_wr && reg_addr == OFS_RATE |=> ##1
    cfg.rate_halves == 4'(8 >> $past(reg_wdata[1:0], 2))) else $error("rate");
  ratio_tie_a: assert property (line_ratio.den == cfg.ref_divisor &&
    line_ratio.num == 10'(cfg.mult_quarters) * 10'(cfg.rate_halves))
    else $error("ratio");
  sync_force_a: assert property (reg_wr && reg_addr == OFS_SYNC &&
    !reg_wdata[0] |=> ##1 !sync_req_low) else $error("sync not forced");
  sync_status_a: assert property (reg_rd && reg_addr == OFS_STATUS |=>
    reg_rdata[STATUS_SYNC_BIT] == $past(sync_req_low)) else $error("status");
  prbs_code_a: assert property (reg_wr && reg_addr == OFS_PRBS |=> ##1
    cfg.prbs_check_en == ($past(reg_wdata[4:0], 2) inside {[1:4]}))
    else $error("pattern");
  reset_pulse_a: assert property (phy_reset |=> !phy_reset)
    else $error("long reset");
  wdog_off_a: assert property (!link_enable [*3] |-> !phy_reset)
    else $error("reset while off");
  cover property (phy_reset);
  cover property (phy_pll_reset);
  cover property (!sync_req_low);
endmodule

/* File: bench/srxp_link_model.sv */
/* Far-end link model: holds its sync request for SYNC_CYC cycles.
 Assumes the same clock and reset as the bank. */
`timescale 1ns/1ps
module srxp_link_model #(
  parameter int SYNC_CYC = 4
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic drop,
  output logic link_up,
  output logic link_sync_req_low
);
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  always_comb begin
    cnt_d = (cnt_q < 8'(SYNC_CYC)) ? cnt_q + 8'h01 : cnt_q;
  end
  always_ff @(posedge sys_clk) begin
    cnt_q <= resetn ? cnt_d : 8'h00;
  end
  // Larger SYNC_CYC models a slow partner
  assign link_sync_req_low = (cnt_q == 8'(SYNC_CYC));
  assign link_up = link_sync_req_low && !drop;
endmodule

/* File: bench/testbench.sv */
/* Testbench for srxp_regs with the link model.
 Assumes inputs driven on the falling edge. */
`timescale 1ns/1ps
module testbench
  import srxp_pkg::*;
;
  logic sys_clk, resetn, reg_wr, reg_rd, link_enable, drop;
  logic [15:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, n, m;
  logic reg_rvalid, link_up, link_sync_req_low, sync_req_low;
  logic phy_reset, phy_pll_reset;
  srxp_cfg_t cfg;
  srxp_ratio_t line_ratio;
  int errors, comparisons;
  localparam logic [15:0] OFS [7] = '{OFS_PHY_PLL_REF_DIVIDER, OFS_MULT, OFS_RATE,
    OFS_VCO, OFS_SYNC, OFS_PRBS, OFS_WDOG};
  localparam logic [7:0] RST [7] = '{RST_PHY_PLL_REF_DIVIDER, RST_MULT, RST_RATE,
    RST_VCO, RST_SYNC, RST_PRBS, RST_WDOG};
  localparam logic [7:0] MC [4] = '{MULT_X4, MULT_X5, MULT_X8Q, MULT_X10};
  localparam logic [5:0] MQ [4] = '{6'h10, 6'h14, 6'h21, 6'h28};
  srxp_regs #(.WDOG_TH1(4), .WDOG_TH2(8), .WDOG_TH3(16), .WDOG_TH4(32))
    uut (.*);
  srxp_link_model p (.sys_clk(sys_clk), .resetn(resetn), .drop(drop),
    .link_up(link_up), .link_sync_req_low(link_sync_req_low));
  task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(logic [15:0] a, logic [7:0] d);
    @(negedge sys_clk) {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(negedge sys_clk) reg_wr = 0;
  endtask
  task automatic rd(logic [15:0] a, logic [7:0] e);
    @(negedge sys_clk) {reg_rd, reg_addr} = {1'b1, a};
    @(negedge sys_clk) reg_rd = 0;
    chk("rvalid", 16'(reg_rvalid), 16'h1);
    chk("rdata", 16'(reg_rdata), 16'(e));
  endtask
  task automatic pulses(logic [7:0] th, logic pll);
    int e;
    e = (th == 0) ? 0 : 40 / th;
    {n, m} = 0;
    repeat (40) begin
      @(negedge sys_clk) n += 8'(phy_reset);
      m += 8'(phy_pll_reset);
    end
    chk("resets", 16'(n), 16'(e));
    chk("pll resets", 16'(m), 16'(pll ? e : 0));
  endtask
  task wrap_up;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    sys_clk = 0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (5000) @(posedge sys_clk);
    errors++;
    wrap_up;
  end
  initial begin
    {resetn, reg_wr, reg_rd, link_enable, drop} = 0;
    {reg_addr, reg_wdata} = 0;
    repeat (8) @(negedge sys_clk);
    resetn = 1;
    for (int i = 0; i < 7; i++) rd(OFS[i], RST[i]);
    rd(16'h0200, 8'h00);
    $display("test reset values done");
    wr(OFS_PHY_PLL_REF_DIVIDER, 8'h08);
    for (int i = 0; i < 4; i++) for (int r = 0; r < 4; r++) begin
      wr(OFS_MULT, MC[i]);
      wr(OFS_RATE, 8'(r));
      @(negedge sys_clk);
      chk("quarters", 16'(cfg.mult_quarters), 16'(MQ[i]));
      chk("valid", 16'(cfg.mult_valid), 16'h1);
      chk("halves", 16'(cfg.rate_halves), 16'(8 >> r));
      chk("num", 16'(line_ratio.num), 16'(MQ[i] * (8 >> r)));
      chk("den", 16'(line_ratio.den), 16'h8);
    end
    wr(OFS_MULT, 8'h11);
    @(negedge sys_clk);
    chk("bad quarters", 16'(cfg.mult_quarters), 16'h0);
    chk("bad valid", 16'(cfg.mult_valid), 16'h0);
    wr(OFS_VCO, 8'h01);
    @(negedge sys_clk);
    chk("vco", 16'(cfg.vco_low_range_flag), 16'h1);
    $display("test decode done");
    for (int c = 0; c < 6; c++) begin
      wr(OFS_PRBS, 8'(c));
      @(negedge sys_clk);
      chk("mode", 16'(cfg.prbs_mode), 16'(c < 5 ? c : 0));
      chk("check", 16'(cfg.prbs_check_en), 16'(c inside {[1:4]}));
    end
    $display("test patterns done");
    wr(OFS_SYNC, 8'h00);
    @(negedge sys_clk);
    chk("sync", 16'(sync_req_low), 16'h0);
    rd(OFS_STATUS, 8'h00);
    wr(OFS_SYNC, 8'h01);
    @(negedge sys_clk);
    rd(OFS_STATUS, 8'(1 << STATUS_SYNC_BIT));
    $display("test sync done");
    drop = 1;
    wr(OFS_WDOG, 8'h81);
    link_enable = 1;
    pulses(8'h4, 1'b1);
    link_enable = 0;
    wr(OFS_WDOG, 8'h01);
    link_enable = 1;
    pulses(8'h4, 1'b0);
    link_enable = 0;
    wr(OFS_WDOG, 8'h80);
    link_enable = 1;
    pulses(8'h0, 1'b1);
    $display("test watchdog done");
    wrap_up;
  end
endmodule
bind srxp_regs srxp_chk chk (.*);
